// ===== src/adc_port_pkg.sv
// constants and helper functions used by the serial port; the fifo takes only parameters
`default_nettype none
package adc_port_pkg;
  // command byte layout
  localparam int CMD_BITS = 8;
  localparam int CMD_RW_BIT = 6;
  localparam int ADDR_W = 6;
  localparam logic [7:0] CMD_CONT_READ = 8'h44;
  // register addresses held inside the port
  localparam logic [5:0] ADDR_STATUS = 6'h00;
  localparam logic [5:0] ADDR_IFMODE = 6'h02;
  localparam logic [5:0] ADDR_DATA = 6'h04;
  // register widths in bits
  localparam logic [5:0] LEN_STATUS = 6'h08;
  localparam logic [5:0] LEN_IFMODE = 6'h10;
  localparam logic [5:0] LEN_DATA = 6'h18;
  localparam logic [5:0] LEN_DATA_STAT = 6'h20;
  localparam logic [5:0] LEN_EXT = 6'h10;
  localparam logic [5:0] LEN_WORD = 6'h20;
  localparam int DATA_BITS = 24;
  localparam int CHAN_BITS = 4;
  // interface mode register fields
  localparam int IFM_CONTREAD = 7;
  localparam int IFM_DATA_STAT = 6;
  localparam int IFM_CHK_LO = 2;
  localparam logic [15:0] IFMODE_RST = 16'h0000;
  // checksum select codes
  localparam logic [1:0] CHK_OFF = 2'h0;
  localparam logic [1:0] CHK_XOR = 2'h1;
  // status byte fields
  localparam int ST_RDY = 7;
  localparam int ST_CHK_ERR = 5;
  // crc generator x^8 + x^2 + x + 1 without the x^8 term
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [6:0] SRST_LAST = 7'h3f;
  localparam int FIFO_DEPTH = 16;
  localparam logic [2:0] SYNC_RST = 3'h6;

  // one message bit into the crc, msb first, zero start, no inversion
  function automatic logic [7:0] crc_step(input logic [7:0] c,
                                          input logic b);
    crc_step = {c[6:0], 1'b0} ^ ((c[7] ^ b) ? CRC_POLY : 8'h00);
  endfunction

  // one message bit into the bytewise xor at its bit position
  function automatic logic [7:0] xor_step(input logic [7:0] x,
                                          input logic b,
                                          input logic [2:0] pos);
    logic [7:0] m;
    m = 8'h00;
    m[3'h7 - pos] = b;
    xor_step = x ^ m;
  endfunction

  // crc after the implied continuous read command
  function automatic logic [7:0] crc_byte(input logic [7:0] v);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      c = crc_step(c, v[i]);
    end
    crc_byte = c;
  endfunction

  // width of a register in bits
  function automatic logic [5:0] reg_len(input logic [5:0] a,
                                         input logic stat);
    if (a == ADDR_STATUS) begin
      reg_len = LEN_STATUS;
    end else if (a == ADDR_IFMODE) begin
      reg_len = LEN_IFMODE;
    end else if (a == ADDR_DATA) begin
      reg_len = stat ? LEN_DATA_STAT : LEN_DATA;
    end else begin
      reg_len = LEN_EXT;
    end
  endfunction
endpackage
`default_nettype wire

// ===== src/adc_serial_port.sv
// serial host port of the converter with ready signalling and checksums
// Notes on behaviour
// RQ1 - all serial data moves only on edges of the host serial clock
// RQ2 - shared output pin falls low on fresh data only while selected
// RQ3 - shared pin returns high after a data register read completes
// RQ4 - ready goes high one step before the data register updates
// RQ5 - host watches ready and finishes reading before the next result
// RQ6 - data rereadable normally; continuous read delivers each result once
// RQ7 - three-wire use with select tied low must work
// RQ8 - status register carries the ready bit for polling
// RQ9 - 64 clocks with input high resets port and registers
// RQ10 - host waits 500 us after a serial reset
// RQ11 - bad write checksum sets the checksum error status flag
// RQ12 - host reads back a protected write to confirm it
// RQ13 - writes are always checked with crc x^8+x^2+x+1
// RQ14 - mode field turns checksum off, or picks crc or xor for reads
// RQ15 - checksum byte follows the last data bit of each transfer
// RQ16 - host write checksum covers command byte plus 8 to 24 data bits
// RQ17 - read checksum covers command byte plus 8 to 32 data bits
// RQ18 - continuous read checksum includes implied command 0x44
// RQ19 - crc is remainder of message with eight zeros appended
// RQ20 - xor checksum combines all message bytes into one byte
// RQ21 - host uses select to address this device on a shared bus
// RQ22 - append option sends status after data, low nibble is channel
// RQ23 - sample input on rising, drive output on falling, msb first
// RQ24 - crc starts at zero, msb first, no final inversion
`default_nettype none
module adc_serial_port (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic i_din,
  output logic o_dout,
  output logic o_dout_oe,
  input wire logic i_conv_valid,
  output logic o_conv_ready,
  input wire logic [23:0] i_conv_data,
  input wire logic [3:0] i_conv_chan,
  input wire logic [15:0] i_ext_rd_data,
  output logic o_ext_wr_stb,
  output logic [5:0] o_ext_wr_addr,
  output logic [23:0] o_ext_wr_data,
  output logic o_soft_rst,
  output logic [15:0] o_ifmode,
  output logic o_rdy_n,
  output logic o_chk_err
);
  typedef enum logic [2:0] {
    ST_CMD, ST_WR, ST_WCHK, ST_RD, ST_RCHK
  } port_st_t;

  port_st_t st_ff;
  logic [2:0] sync_ff [3];
  logic [2:0] lvl_ff;
  logic [2:0] raw;
  logic cs_n_l;
  logic sclk_l;
  logic din_l;
  logic rise;
  logic fall;
  logic [5:0] cnt_ff;
  logic [5:0] len_ff;
  logic [5:0] addr_ff;
  logic [23:0] in_sr_ff;
  logic [31:0] out_sr_ff;
  logic [7:0] crc_ff;
  logic [7:0] xor_ff;
  logic [7:0] chk_in_ff;
  logic fin_ff;
  logic dout_ff;
  logic wr_stb_ff;
  logic chk_bad_ff;
  logic rd_done_ff;
  logic [6:0] ones_ff;
  logic srst_ff;
  logic [15:0] ifmode_ff;
  logic [23:0] data_ff;
  logic [3:0] chan_ff;
  logic rdy_n_ff;
  logic upd_ff;
  logic taken_ff;
  logic chk_err_ff;
  logic [1:0] chk_sel;
  logic cont;
  logic stat_on;
  logic reading;
  logic data_busy;
  logic fifo_vld;
  logic fifo_pop;
  logic [27:0] fifo_q;
  logic [7:0] cmd_byte;
  logic [7:0] status_byte;
  logic [31:0] rd_word;
  logic [7:0] crc_nx;
  logic [7:0] xor_nx;
  logic [7:0] crc_out_nx;
  logic [7:0] xor_out_nx;
  logic [5:0] len_cmd;

  // idle level of one synchronised pin, used as its reset value
  function automatic logic sync_rst_bit(input int b);
    sync_rst_bit = adc_port_pkg::SYNC_RST[b];
  endfunction

  // three-stage synchronisers for select, clock and data
  assign raw = {i_cs_n, i_sclk, i_din};
  for (genvar g = 0; g < 3; g++) begin : g_sync
    always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        sync_ff[g] <= {3{sync_rst_bit(g)}};
        lvl_ff[g] <= sync_rst_bit(g);
      end else if (i_ce) begin
        sync_ff[g] <= {sync_ff[g][1:0], raw[g]};
        // accept a change once stages two and three agree
        if (sync_ff[g][1] == sync_ff[g][2]) begin
          lvl_ff[g] <= sync_ff[g][2];
        end
      end
    end
  end

  // filtered levels and serial clock edges
  assign cs_n_l = lvl_ff[2];
  assign sclk_l = lvl_ff[1];
  assign din_l = lvl_ff[0];
  assign rise = (sync_ff[1][1] == sync_ff[1][2]) && sync_ff[1][2]
                && !sclk_l; // RQ1
  assign fall = (sync_ff[1][1] == sync_ff[1][2]) && !sync_ff[1][2]
                && sclk_l; // RQ1

  // mode decode from the interface mode register
  assign chk_sel = ifmode_ff[adc_port_pkg::IFM_CHK_LO +: 2];
  assign cont = ifmode_ff[adc_port_pkg::IFM_CONTREAD];
  assign stat_on = ifmode_ff[adc_port_pkg::IFM_DATA_STAT];
  assign reading = (st_ff == ST_RD) || (st_ff == ST_RCHK);
  assign data_busy = reading && (addr_ff == adc_port_pkg::ADDR_DATA);
  assign cmd_byte = {in_sr_ff[6:0], din_l};
  assign len_cmd = adc_port_pkg::reg_len(cmd_byte[5:0], stat_on);

  // status byte: ready, checksum error, source channel
  always_comb begin
    status_byte = 8'h00;
    status_byte[adc_port_pkg::ST_RDY] = rdy_n_ff; // RQ8
    status_byte[adc_port_pkg::ST_CHK_ERR] = chk_err_ff; // RQ11
    status_byte[3:0] = chan_ff; // RQ22
  end

  // read word selected by the command address, right aligned
  always_comb begin
    if (cmd_byte[5:0] == adc_port_pkg::ADDR_STATUS) begin
      rd_word = {24'h000000, status_byte};
    end else if (cmd_byte[5:0] == adc_port_pkg::ADDR_IFMODE) begin
      rd_word = {16'h0000, ifmode_ff};
    end else if (cmd_byte[5:0] == adc_port_pkg::ADDR_DATA) begin
      rd_word = stat_on ? {data_ff, status_byte} : {8'h00, data_ff}; // RQ22
    end else begin
      rd_word = {16'h0000, i_ext_rd_data};
    end
  end

  // running checksums for a sampled bit and for a driven bit
  assign crc_nx = adc_port_pkg::crc_step(crc_ff, din_l); // RQ19
  assign xor_nx = adc_port_pkg::xor_step(xor_ff, din_l, cnt_ff[2:0]);
  assign crc_out_nx = adc_port_pkg::crc_step(crc_ff, out_sr_ff[31]);
  assign xor_out_nx = adc_port_pkg::xor_step(xor_ff, out_sr_ff[31],
                                             cnt_ff[2:0]); // RQ20

  // serial engine; select high aborts any partial transfer
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff <= ST_CMD;
      cnt_ff <= 6'h00;
      len_ff <= 6'h00;
      addr_ff <= 6'h00;
      in_sr_ff <= 24'h000000;
      out_sr_ff <= 32'h00000000;
      crc_ff <= 8'h00;
      xor_ff <= 8'h00;
      chk_in_ff <= 8'h00;
      fin_ff <= 1'b0;
      dout_ff <= 1'b1;
      wr_stb_ff <= 1'b0;
      chk_bad_ff <= 1'b0;
      rd_done_ff <= 1'b0;
    end else if (i_ce) begin
      wr_stb_ff <= 1'b0;
      chk_bad_ff <= 1'b0;
      rd_done_ff <= 1'b0;
      if (srst_ff || cs_n_l) begin
        st_ff <= ST_CMD; // RQ9
        cnt_ff <= 6'h00;
        crc_ff <= 8'h00; // RQ24
        xor_ff <= 8'h00;
        fin_ff <= 1'b0;
      end else begin
        unique case (st_ff)
          ST_CMD: begin
            if (cont && !rdy_n_ff && !taken_ff) begin
              // continuous read: no command, seed with implied byte
              st_ff <= ST_RD; // RQ6
              addr_ff <= adc_port_pkg::ADDR_DATA;
              len_ff <= adc_port_pkg::reg_len(adc_port_pkg::ADDR_DATA,
                                               stat_on);
              out_sr_ff <= stat_on ? {data_ff, status_byte}
                                   : {data_ff, 8'h00};
              crc_ff <= adc_port_pkg::crc_byte(
                          adc_port_pkg::CMD_CONT_READ); // RQ18
              xor_ff <= adc_port_pkg::CMD_CONT_READ; // RQ18
              cnt_ff <= 6'h00;
            end else if (rise && !cont) begin
              in_sr_ff <= {in_sr_ff[22:0], din_l}; // RQ23
              crc_ff <= crc_nx; // RQ13
              xor_ff <= xor_nx;
              cnt_ff <= cnt_ff + 6'h01;
              if (cnt_ff == 6'(adc_port_pkg::CMD_BITS - 1)) begin
                addr_ff <= cmd_byte[5:0];
                len_ff <= len_cmd;
                cnt_ff <= 6'h00;
                if (cmd_byte[adc_port_pkg::CMD_RW_BIT]) begin
                  st_ff <= ST_RD; // RQ17
                  out_sr_ff <= rd_word << (adc_port_pkg::LEN_WORD
                                           - len_cmd);
                end else begin
                  st_ff <= ST_WR; // RQ16
                  // drop the command bits so write data lands right aligned
                  in_sr_ff <= 24'h000000;
                end
              end
            end
          end
          ST_WR: begin
            if (rise) begin
              in_sr_ff <= {in_sr_ff[22:0], din_l}; // RQ23
              crc_ff <= crc_nx; // RQ13
              cnt_ff <= cnt_ff + 6'h01;
              if (cnt_ff == len_ff - 6'h01) begin
                cnt_ff <= 6'h00;
                if (chk_sel != adc_port_pkg::CHK_OFF) begin
                  st_ff <= ST_WCHK; // RQ15
                end else begin
                  st_ff <= ST_CMD;
                  wr_stb_ff <= 1'b1;
                  crc_ff <= 8'h00;
                  xor_ff <= 8'h00;
                end
              end
            end
          end
          ST_WCHK: begin
            if (rise) begin
              chk_in_ff <= {chk_in_ff[6:0], din_l};
              cnt_ff <= cnt_ff + 6'h01;
              if (cnt_ff == 6'h07) begin
                // writes are checked by crc whatever the read choice
                if ({chk_in_ff[6:0], din_l} == crc_ff) begin // RQ13
                  wr_stb_ff <= 1'b1;
                end else begin
                  chk_bad_ff <= 1'b1; // RQ11
                end
                st_ff <= ST_CMD;
                cnt_ff <= 6'h00;
                crc_ff <= 8'h00;
                xor_ff <= 8'h00;
              end
            end
          end
          ST_RD, ST_RCHK: begin
            if (fall && !fin_ff) begin
              dout_ff <= out_sr_ff[31]; // RQ23
              out_sr_ff <= {out_sr_ff[30:0], 1'b0};
              cnt_ff <= cnt_ff + 6'h01;
              if (st_ff == ST_RD) begin
                crc_ff <= crc_out_nx; // RQ17
                xor_ff <= xor_out_nx;
                if (cnt_ff == len_ff - 6'h01) begin
                  cnt_ff <= 6'h00;
                  if (chk_sel == adc_port_pkg::CHK_OFF) begin
                    fin_ff <= 1'b1;
                  end else begin
                    // checksum rides right behind the last data bit
                    st_ff <= ST_RCHK; // RQ15
                    out_sr_ff <= {(chk_sel == adc_port_pkg::CHK_XOR)
                                  ? xor_out_nx : crc_out_nx,
                                  24'h000000}; // RQ14
                  end
                end
              end else if (cnt_ff == 6'h07) begin
                fin_ff <= 1'b1;
              end
            end else if (rise && fin_ff) begin
              // hold the last bit until the host has sampled it
              rd_done_ff <= 1'b1;
              fin_ff <= 1'b0;
              st_ff <= ST_CMD;
              cnt_ff <= 6'h00;
              crc_ff <= 8'h00;
              xor_ff <= 8'h00;
            end
          end
        endcase
      end
    end
  end

  // serial reset: 64 rising clocks with select low and input high
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ones_ff <= 7'h00;
      srst_ff <= 1'b0;
    end else if (i_ce) begin
      srst_ff <= 1'b0;
      if (cs_n_l) begin
        ones_ff <= 7'h00;
      end else if (rise) begin
        if (!din_l) begin
          ones_ff <= 7'h00;
        end else if (ones_ff == adc_port_pkg::SRST_LAST) begin
          ones_ff <= 7'h00;
          srst_ff <= 1'b1; // RQ9
        end else begin
          ones_ff <= ones_ff + 7'h01;
        end
      end
    end
  end

  // interface mode register, restored by the serial reset
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ifmode_ff <= adc_port_pkg::IFMODE_RST;
    end else if (i_ce) begin
      if (srst_ff) begin
        ifmode_ff <= adc_port_pkg::IFMODE_RST; // RQ9
      end else if (wr_stb_ff && addr_ff == adc_port_pkg::ADDR_IFMODE) begin
        ifmode_ff <= in_sr_ff[15:0]; // RQ14
      end
    end
  end

  // checksum error flag; a new error wins over the clearing read
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      chk_err_ff <= 1'b0;
    end else if (i_ce) begin
      if (srst_ff) begin
        chk_err_ff <= 1'b0;
      end else if (chk_bad_ff) begin
        chk_err_ff <= 1'b1; // RQ11
      end else if (rd_done_ff && addr_ff == adc_port_pkg::ADDR_STATUS) begin
        chk_err_ff <= 1'b0;
      end
    end
  end

  // conversion words wait in the fifo while a data read is running
  adc_word_fifo #(
    .WIDTH(adc_port_pkg::DATA_BITS + adc_port_pkg::CHAN_BITS),
    .DEPTH(adc_port_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_in_valid(i_conv_valid),
    .o_in_ready(o_conv_ready),
    .i_in_data({i_conv_data, i_conv_chan}),
    .o_out_valid(fifo_vld),
    .i_out_ready(fifo_pop),
    .o_out_data(fifo_q)
  );

  assign fifo_pop = upd_ff && !data_busy;

  // data register update: raise ready, then load and drop ready
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      upd_ff <= 1'b0;
      rdy_n_ff <= 1'b1;
      taken_ff <= 1'b0;
      data_ff <= 24'h000000;
      chan_ff <= 4'h0;
    end else if (i_ce) begin
      if (srst_ff) begin
        upd_ff <= 1'b0;
        rdy_n_ff <= 1'b1;
        taken_ff <= 1'b0;
        data_ff <= 24'h000000;
        chan_ff <= 4'h0;
      end else if (fifo_pop) begin
        data_ff <= fifo_q[27:4];
        chan_ff <= fifo_q[3:0]; // RQ22
        rdy_n_ff <= 1'b0; // RQ2
        taken_ff <= 1'b0;
        upd_ff <= 1'b0;
      end else if (fifo_vld && !upd_ff && !data_busy) begin
        // warn the host off before the word changes
        upd_ff <= 1'b1;
        rdy_n_ff <= 1'b1; // RQ4
      end else if (rd_done_ff && addr_ff == adc_port_pkg::ADDR_DATA) begin
        rdy_n_ff <= 1'b1; // RQ3
        taken_ff <= 1'b1; // RQ6
      end
    end
  end

  // shared pin: data during a read, otherwise inverted ready
  assign o_dout = reading ? dout_ff : rdy_n_ff; // RQ2
  // driven only while selected; select tied low gives three-wire use
  assign o_dout_oe = !cs_n_l; // RQ7

  // write strobe for registers kept outside this port
  assign o_ext_wr_stb = wr_stb_ff
                        && (addr_ff != adc_port_pkg::ADDR_STATUS)
                        && (addr_ff != adc_port_pkg::ADDR_IFMODE)
                        && (addr_ff != adc_port_pkg::ADDR_DATA);
  assign o_ext_wr_addr = addr_ff;
  assign o_ext_wr_data = in_sr_ff;
  assign o_soft_rst = srst_ff; // RQ9
  assign o_ifmode = ifmode_ff;
  assign o_rdy_n = rdy_n_ff;
  assign o_chk_err = chk_err_ff;
endmodule
`default_nettype wire

// ===== src/adc_word_fifo.sv
// flip-flop fifo carrying conversion words toward the data register
`default_nettype none
module adc_word_fifo #(
  parameter int WIDTH = 28,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0] cnt_ff;
  logic push;
  logic pop;

  // full and empty follow the occupancy count
  assign o_in_ready = (cnt_ff != (AW+1)'(DEPTH));
  assign o_out_valid = (cnt_ff != '0);
  assign o_out_data = mem_ff[rd_ff];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  // storage is written only, never reset
  always_ff @(posedge i_clk) begin
    if (i_ce && push) begin
      mem_ff[wr_ff] <= i_in_data;
    end
  end

  // pointers wrap; depth is a power of two
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else if (i_ce) begin
      if (push) begin
        wr_ff <= wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= rd_ff + 1'b1;
      end
      if (push && !pop) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (pop && !push) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== test/adc_host_model.sv
// host serial master model driving select, clock and data in
`default_nettype none
module adc_host_model (
  input wire logic i_clk,
  input wire logic i_dout,
  input wire logic i_hold_sel,
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_din
);
  timeunit 1ns;
  timeprecision 1ps;
  // clock idles high, nothing selected at power-up
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b1;
    o_din = 1'b1;
  end
  // one frame msb first; long low phase covers the output sync delay
  task automatic xfer(input logic [63:0] tx, input int n,
                      output logic [63:0] rx);
    rx = 64'h0;
    o_cs_n <= 1'b0;
    repeat (4) @(posedge i_clk);
    for (int i = n - 1; i >= 0; i--) begin
      o_sclk <= 1'b0;
      o_din <= tx[i];
      repeat (5) @(posedge i_clk);
      rx = {rx[62:0], i_dout};
      o_sclk <= 1'b1;
      repeat (3) @(posedge i_clk);
    end
    repeat (2) @(posedge i_clk);
    o_cs_n <= i_hold_sel ? 1'b0 : 1'b1;
    o_din <= ~o_din; // no stale level once released
    repeat (6) @(posedge i_clk);
  endtask
  // 64 rises with din high, then the settle time before any frame
  task automatic serial_reset();
    logic [63:0] rx;
    xfer(64'hffff_ffff_ffff_ffff, 64, rx);
    repeat (20000) @(posedge i_clk);
  endtask
endmodule
`default_nettype wire

// ===== test/adc_serial_port_properties.sv
// pin-level assertion checker for the converter serial port
`default_nettype none
module adc_serial_port_properties (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_cs_n,
  input wire logic i_din,
  input wire logic o_dout,
  input wire logic o_dout_oe,
  input wire logic o_rdy_n,
  input wire logic o_chk_err,
  input wire logic o_ext_wr_stb,
  input wire logic o_soft_rst,
  input wire logic [15:0] o_ifmode
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  // select held long enough to clear the three-stage pin filter
  sequence s_idle;
    i_cs_n [*5];
  endsequence
  sequence s_sel;
    !i_cs_n [*5];
  endsequence
  a_idle_no_drive: assert property (s_idle |-> !o_dout_oe)
    else $error("pin driven while deselected");
  a_sel_drives: assert property (s_sel |-> o_dout_oe)
    else $error("pin not driven while selected");
  a_idle_mirror: assert property
    ((i_cs_n && $stable(o_rdy_n)) [*6] |-> o_dout == o_rdy_n)
    else $error("idle pin does not show ready");
  // a load needs its warning cycle first, so no fall right after a reset
  a_rdy_warns: assert property
    ($fell(o_rdy_n) |-> !$past(o_soft_rst, 1) && !$past(o_soft_rst, 2))
    else $error("ready fell without a high warning cycle");
  a_err_no_write: assert property ($rose(o_chk_err) |-> !o_ext_wr_stb)
    else $error("write strobed despite bad checksum");
  a_rst_cause: assert property
    (o_soft_rst |-> $past(i_din, 5) && !$past(i_cs_n, 5))
    else $error("soft reset without din high and select");
  a_rst_clears: assert property
    (o_soft_rst |-> ##[0:2] (o_ifmode == 16'h0000 && !o_chk_err))
    else $error("soft reset left registers set");
  a_rst_single: assert property (o_soft_rst |=> !o_soft_rst [*8])
    else $error("soft reset pulse repeated");
endmodule
bind adc_serial_port adc_serial_port_properties u_props (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_cs_n(i_cs_n), .i_din(i_din),
  .o_dout(o_dout), .o_dout_oe(o_dout_oe), .o_rdy_n(o_rdy_n),
  .o_chk_err(o_chk_err), .o_ext_wr_stb(o_ext_wr_stb),
  .o_soft_rst(o_soft_rst), .o_ifmode(o_ifmode));
`default_nettype wire

// ===== test/adc_serial_port_tb.sv
// self-checking bench for the converter serial port
`default_nettype none
module adc_serial_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, hold_sel = 1'b0, conv_valid = 1'b0;
  logic cs_n, sclk, din, dout, dout_oe, conv_ready, ext_stb;
  logic soft_rst, rdy_n, chk_err;
  logic [23:0] conv_data = 24'h0, ext_wdata, wr_data;
  logic [3:0] conv_chan = 4'h0;
  logic [15:0] ext_rd = 16'ha5c3, ifmode;
  logic [5:0] ext_addr, wr_addr;
  logic [63:0] rx;
  int mismatches = 0, n_checks = 0, cycles = 0, rst_seen = 0;
  always #12.5 clk = ~clk;
  adc_serial_port dut (.i_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1),
    .i_cs_n(cs_n), .i_sclk(sclk), .i_din(din), .o_dout(dout),
    .o_dout_oe(dout_oe), .i_conv_valid(conv_valid),
    .o_conv_ready(conv_ready), .i_conv_data(conv_data),
    .i_conv_chan(conv_chan), .i_ext_rd_data(ext_rd),
    .o_ext_wr_stb(ext_stb), .o_ext_wr_addr(ext_addr),
    .o_ext_wr_data(ext_wdata), .o_soft_rst(soft_rst), .o_ifmode(ifmode),
    .o_rdy_n(rdy_n), .o_chk_err(chk_err));
  adc_host_model host (.i_clk(clk), .i_dout(dout), .i_hold_sel(hold_sel),
    .o_cs_n(cs_n), .o_sclk(sclk), .o_din(din));
  // catch one-cycle pulses for later judgement
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (soft_rst === 1'b1) rst_seen <= rst_seen + 1;
    if (ext_stb === 1'b1) wr_addr <= ext_addr;
    if (ext_stb === 1'b1) wr_data <= ext_wdata;
  end
  // hang guard, well above the expected run length
  always @(posedge clk) begin
    if (cycles == 45000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // reference checksum, bit serial so it shares nothing with the design
  function automatic logic [7:0] crc8(input logic [63:0] m, input int n);
    logic [7:0] c;
    c = 8'h00;
    for (int i = n - 1; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ m[i]) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction
  task automatic rd(input logic [7:0] cmd, input int nd);
    host.xfer(64'(cmd) << nd, nd + 8, rx);
    rx = rx & ((64'h1 << nd) - 64'h1);
  endtask
  task automatic wr(input logic [7:0] cmd, input logic [23:0] d,
                    input int nd, input int nc, input logic [7:0] flip);
    logic [63:0] m;
    m = (64'(cmd) << nd) | 64'(d);
    if (nc > 0) m = (m << 8) | 64'(crc8(m, nd + 8) ^ flip);
    host.xfer(m, nd + 8 + nc, rx);
  endtask
  // valid held until the edge where ready is seen high
  task automatic push(input logic [23:0] d, input logic [3:0] ch);
    conv_valid <= 1'b1;
    conv_data <= d;
    conv_chan <= ch;
    for (int k = 0; k < 100; k++) begin
      @(negedge clk);
      if (conv_ready === 1'b1) break;
    end
    @(posedge clk);
    conv_valid <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_rdy();
    for (int k = 0; k < 400 && rdy_n !== 1'b0; k++) @(negedge clk);
    @(posedge clk);
  endtask
  task automatic t_status();
    chk({ifmode, rdy_n, chk_err, dout_oe, dout, conv_ready},
        {16'h0000, 5'h13});
    rd(8'h40, 8);
    chk(rx, 64'h80);
  endtask
  task automatic t_data();
    push(24'h111111, 4'h1);
    push(24'h654321, 4'h5);
    repeat (10) @(posedge clk);
    wait_rdy();
    rd(8'h40, 8);
    chk(rx, 64'h05);
    rd(8'h44, 24);
    chk(rx, 64'h654321);
    chk(rdy_n, 1'b1);
    rd(8'h44, 24);
    chk(rx, 64'h654321);
  endtask
  task automatic t_crc();
    // checksum still off here, so this write carries no checksum byte
    wr(8'h02, 24'h0008, 16, 0, 8'h00);
    chk(ifmode, 64'h0008);
    wr(8'h02, 24'h0004, 16, 8, 8'h01);
    chk({ifmode, chk_err}, {16'h0008, 1'b1});
    rd(8'h40, 16);
    chk(rx, {8'ha5, crc8(64'h40a5, 16)});
    chk(chk_err, 1'b0);
    rd(8'h40, 16);
    chk(rx, {8'h85, crc8(64'h4085, 16)});
  endtask
  task automatic t_xor();
    wr(8'h02, 24'h0004, 16, 8, 8'h00);
    rd(8'h42, 24);
    chk(rx, {16'h0004, 8'h42 ^ 8'h00 ^ 8'h04});
  endtask
  task automatic t_cont();
    wr(8'h02, 24'h00c8, 16, 8, 8'h00);
    push(24'h000000, 4'h3);
    wait_rdy();
    host.xfer(64'h0, 40, rx);
    chk(rx[39:0], {32'h03, crc8(64'h4400000003, 40)});
    chk(rdy_n, 1'b1);
  endtask
  task automatic t_sreset();
    host.serial_reset();
    chk({rst_seen, ifmode, chk_err}, {32'd1, 16'h0000, 1'b0});
    rd(8'h40, 8);
    chk(rx, 64'h80);
  endtask
  task automatic t_three_wire();
    hold_sel <= 1'b1;
    @(posedge clk);
    rd(8'h40, 8);
    chk(rx, 64'h80);
    wr(8'h10, 24'h1234, 16, 0, 8'h00);
    chk({wr_addr, wr_data}, {6'h10, 24'h001234});
    rd(8'h50, 16);
    chk(rx, 64'ha5c3);
    chk(dout_oe, 1'b1);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    t_status();
    t_data();
    t_crc();
    t_xor();
    t_cont();
    t_sreset();
    t_three_wire();
    report_and_stop();
  end
endmodule
`default_nettype wire
